// file: scp_pkg.sv
// Purpose: shared constants for the serial configuration port
// Assumes: register contents live outside the port
// Notes: widths are in bytes, one to four
package scp_pkg;
    localparam int SCP_INSTR_BITS = 8;
    localparam int SCP_DIR_BIT = 7;
    localparam int SCP_ADDR_MSB = 4;
    localparam int SCP_ADDR_W = 5;
    localparam int SCP_DATA_W = 32;
    localparam int SCP_BYTES_W = 3;
    localparam int SCP_RESYNC_EDGES = 8;
    localparam logic [2:0] SCP_BIT_LAST = 3'h7;
    localparam logic [2:0] SCP_BIT_FIRST = 3'h0;
    localparam logic [1:0] SCP_SYNC_INIT = 2'h0;
    localparam logic [7:0] SCP_BYTE_ZERO = 8'h00;
    localparam real SCP_SCLK_MAX_MHZ = 40.0;
    typedef enum logic [1:0] {
        SCP_ST_INSTR = 2'b01,
        SCP_ST_DATA = 2'b10
    } scp_state_t;
endpackage

// file: scp_sync.sv
// Purpose: three-stage level synchroniser with agreement filter
// Assumes: input is asynchronous to clk
// Notes: output changes once stages two and three agree
`timescale 1ns/100ps
module scp_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    import scp_pkg::*;
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic out_reg;
    wire agree = (s2_reg == s3_reg);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            out_reg <= 1'b0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (agree) begin
                out_reg <= s3_reg;
            end
        end
    end
    assign dout = out_reg;
endmodule

// file: scp_bytes.sv
// Purpose: byte selection helpers for the shift datapath
// Assumes: byte index is below the register width
// Notes: picks or merges one byte of a 32-bit word
`timescale 1ns/100ps
module scp_bytes (
    input wire logic [31:0] word,
    input wire logic [1:0] sel,
    input wire logic [7:0] new_byte,
    output logic [7:0] pick,
    output logic [31:0] merged
);
    import scp_pkg::*;
    genvar g;
    wire [7:0] lanes [4];
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign lanes[g] = word[g*8 +: 8];
            assign merged[g*8 +: 8] = (sel == 2'(g)) ? new_byte : word[g*8 +: 8];
        end
    endgenerate
    assign pick = lanes[sel];
endmodule

// file: scp_port.sv
// Purpose: serial configuration port slave, instruction then data phase
// Assumes: register file outside answers rd_data for rd_addr at once
// Notes: link logic runs on sclk; controls cross into core_clk
// Functional notes
// - first eight rising edges form instruction
// - instruction bit 7 set means read
// - instruction bits 6 and 5 ignored
// - bits 4..0 select the register
// - data phase length equals register width
// - whole register per cycle only
// - after cycle, next eight edges instruction
// - sample input data on rising edge
// - launch read data on falling edge
// - select high floats both data pins
// - select high suspends cycle, progress kept
// - three-wire bit chooses pin mode
// - three-wire mode floats separate output pin
// - bit-order control: low msb first
// - msb mode: bytes high to low
// - lsb mode: bytes low to high
// - eight clocks with select high resync
`timescale 1ns/100ps
module scp_port #(
    parameter int ADDR_W = scp_pkg::SCP_ADDR_W,
    parameter int DATA_W = scp_pkg::SCP_DATA_W
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic port_select_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic serial_data_out_pin,
    output logic serial_data_out_oe,
    input wire logic three_wire_cfg,
    input wire logic lsb_first_cfg,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic [scp_pkg::SCP_BYTES_W-1:0] reg_bytes,
    output logic wr_strobe,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [DATA_W-1:0] wr_data,
    output logic busy
);
    import scp_pkg::*;

    // config pins are core-side levels; filtered into the sclk domain
    logic three_wire;
    logic lsb_first;
    scp_sync u_tw_sync (
        .clk(sclk),
        .rst(rst),
        .din(three_wire_cfg),
        .dout(three_wire)
    );
    scp_sync u_lf_sync (
        .clk(sclk),
        .rst(rst),
        .din(lsb_first_cfg),
        .dout(lsb_first)
    );

    scp_state_t state_reg;
    scp_state_t state_next;
    logic [2:0] bit_cnt_reg;
    logic [1:0] byte_idx_reg;
    logic [2:0] bytes_left_reg;
    logic [7:0] shift_reg;
    logic is_read_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] word_reg;
    logic [3:0] resync_cnt_reg;
    logic wr_toggle_reg;
    logic out_bit_reg;

    // next byte of the instruction/data, honouring bit order
    wire [7:0] shifted = lsb_first ? {sdio_in, shift_reg[7:1]}
                                   : {shift_reg[6:0], sdio_in};
    wire byte_done = (bit_cnt_reg == SCP_BIT_LAST);
    wire instr_dir = shifted[SCP_DIR_BIT];
    wire [ADDR_W-1:0] instr_addr = shifted[SCP_ADDR_MSB:0];
    wire [2:0] width = (reg_bytes == 3'h0) ? 3'h1 : reg_bytes;
    wire [1:0] last_idx = 2'(width - 3'h1);
    wire [1:0] first_idx = lsb_first ? 2'h0 : last_idx;
    wire [1:0] step_idx = lsb_first ? 2'(byte_idx_reg + 2'h1)
                                    : 2'(byte_idx_reg - 2'h1);
    wire resync_hit = (resync_cnt_reg == 4'(SCP_RESYNC_EDGES - 1));

    logic [7:0] cur_byte;
    logic [31:0] merged_word;
    scp_bytes u_bytes (
        .word(word_reg),
        .sel(byte_idx_reg),
        .new_byte(shifted),
        .pick(cur_byte),
        .merged(merged_word)
    );

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SCP_ST_INSTR: if (byte_done) state_next = SCP_ST_DATA;
            SCP_ST_DATA: if (byte_done && bytes_left_reg == 3'h1) begin
                state_next = SCP_ST_INSTR;
            end
        endcase
    end

    // chip select high: no sclk edge advances the cycle; edges are counted and the eighth returns it to the instruction phase
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            resync_cnt_reg <= 4'h0;
        end else if (!port_select_n) begin
            resync_cnt_reg <= 4'h0;
        end else if (!resync_hit) begin
            resync_cnt_reg <= 4'(resync_cnt_reg + 4'h1);
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            state_reg <= SCP_ST_INSTR;
            bit_cnt_reg <= SCP_BIT_FIRST;
            byte_idx_reg <= 2'h0;
            bytes_left_reg <= 3'h0;
            shift_reg <= SCP_BYTE_ZERO;
            is_read_reg <= 1'b0;
            addr_reg <= '0;
            word_reg <= '0;
            wr_toggle_reg <= 1'b0;
        end else if (port_select_n) begin
            if (resync_hit) begin
                state_reg <= SCP_ST_INSTR;
                bit_cnt_reg <= SCP_BIT_FIRST;
            end
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= 3'(bit_cnt_reg + 3'h1);
            shift_reg <= shifted;
            if (state_reg == SCP_ST_INSTR && byte_done) begin
                is_read_reg <= instr_dir;
                addr_reg <= instr_addr;
                bytes_left_reg <= width;
                byte_idx_reg <= first_idx;
                word_reg <= rd_data;
            end else if (state_reg == SCP_ST_DATA && byte_done) begin
                bytes_left_reg <= 3'(bytes_left_reg - 3'h1);
                byte_idx_reg <= step_idx;
                if (!is_read_reg) begin
                    word_reg <= merged_word;
                    if (bytes_left_reg == 3'h1) begin
                        wr_toggle_reg <= ~wr_toggle_reg;
                    end
                end
            end
        end
    end

    // read bit for the next rising edge, launched on falling edge
    wire [2:0] out_pos = lsb_first ? bit_cnt_reg : 3'(SCP_BIT_LAST - bit_cnt_reg);
    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            out_bit_reg <= 1'b0;
        end else if (!port_select_n) begin
            out_bit_reg <= cur_byte[out_pos];
        end
    end

    wire reading = (state_reg == SCP_ST_DATA) && is_read_reg && !port_select_n;
    assign rd_addr = (state_reg == SCP_ST_INSTR) ? instr_addr : addr_reg;
    assign sdio_out = out_bit_reg;
    assign sdio_oe = reading && three_wire;
    assign serial_data_out_pin = out_bit_reg;
    assign serial_data_out_oe = reading && !three_wire;

    // write completion crosses to core_clk as a toggle
    logic wr_sync_out;
    logic wr_seen_reg;
    logic wr_strobe_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [DATA_W-1:0] wr_data_reg;
    scp_sync u_wr_sync (
        .clk(core_clk),
        .rst(rst),
        .din(wr_toggle_reg),
        .dout(wr_sync_out)
    );
    wire wr_event = wr_sync_out ^ wr_seen_reg;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_seen_reg <= 1'b0;
            wr_strobe_reg <= 1'b0;
            wr_addr_reg <= '0;
            wr_data_reg <= '0;
        end else begin
            wr_seen_reg <= wr_sync_out;
            wr_strobe_reg <= wr_event;
            // word and addr stable long before toggle is seen
            if (wr_event) begin
                wr_addr_reg <= addr_reg;
                wr_data_reg <= word_reg;
            end
        end
    end
    assign wr_strobe = wr_strobe_reg;
    assign wr_addr = wr_addr_reg;
    assign wr_data = wr_data_reg;

    logic busy_sync;
    scp_sync u_busy_sync (
        .clk(core_clk),
        .rst(rst),
        .din(state_reg == SCP_ST_DATA),
        .dout(busy_sync)
    );
    assign busy = busy_sync;
endmodule

// file: scp_port_assertions.sv
// Purpose: port checker
// Assumes: sees scp_port ports only
// Notes: sclk side is sampled on core_clk
`timescale 1ns/100ps
module scp_port_chk #(
    parameter int ADDR_W = 5,
    parameter int DATA_W = 32
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic port_select_n,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic serial_data_out_pin,
    input wire logic serial_data_out_oe,
    input wire logic three_wire_cfg,
    input wire logic [ADDR_W-1:0] rd_addr,
    input wire logic wr_strobe,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic busy
);
    wire oe_any = sdio_oe || serial_data_out_oe;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    AST_CS_FLOAT: assert property (port_select_n && $past(port_select_n) |-> !oe_any)
        else $error("cs float");
    AST_SDO_3W: assert property (serial_data_out_oe |-> !three_wire_cfg)
        else $error("sdo in 3w");
    AST_SDIO_4W: assert property (sdio_oe |-> three_wire_cfg && !port_select_n)
        else $error("sdio oe");
    AST_STB_PULSE: assert property (wr_strobe |=> !wr_strobe)
        else $error("strobe long");
    AST_WR_HOLD: assert property ($changed(wr_addr) || $changed(wr_data) |-> ##[0:1] wr_strobe)
        else $error("wr moved");
    // a 62.5 ns high phase spans several core edges, so one launch on a rise shows up
    AST_OUT_FALL: assert property (sclk && $past(sclk) |-> sdio_out == $past(sdio_out, 2) &&
        serial_data_out_pin == $past(serial_data_out_pin, 2)) else $error("rise launch");
    AST_ADDR_HOLD: assert property (oe_any && $past(oe_any) |-> $stable(rd_addr))
        else $error("addr moved");
    AST_BUSY_RD: assert property ($rose(oe_any) |-> ##[0:8] busy)
        else $error("no busy");
    cover property (wr_strobe);
    cover property ($rose(sdio_oe));
    cover property ($rose(serial_data_out_oe));
endmodule
bind scp_port scp_port_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_i (.*);

// file: scp_host.sv
// Purpose: serial master model
// Assumes: one frame at a time
// Notes: clock idles low, 125 ns period
`timescale 1ns/100ps
module scp_host (
    output logic sclk = 0,
    output logic port_select_n = 1,
    output logic sdi = 0,
    input wire logic miso
);
    // select may stay low after a frame while sclk is idle
    logic keep_low = 0;
    task automatic resync();
        port_select_n = 1;
        repeat (9) begin
            #62.5 sclk = 1;
            #62.5 sclk = 0;
        end
    endtask
    // select drops out before bit brk and returns after a pause
    task automatic xfer(input logic [7:0] ins, input logic [31:0] wd,
            input int nb, lsb, brk, output logic [31:0] rd);
        logic [39:0] v;
        v = lsb ? {wd, ins} : {ins, wd << (32 - 8 * nb)};
        rd = '0;
        port_select_n = 0;
        for (int i = 0; i < 8 + 8 * nb; i++) begin
            if (i == brk) begin
                port_select_n = 1;
                #300 port_select_n = 0;
            end
            sdi = lsb ? v[i] : v[39 - i];
            #62.5 sclk = 1;
            if (i > 7 && lsb) rd[i - 8] = miso;
            else if (i > 7) rd = {rd[30:0], miso};
            #62.5 sclk = 0;
        end
        port_select_n = keep_low;
        sdi = ~sdi;
    endtask
endmodule

// file: tb_serial_config_port.sv
// Purpose: random traffic bench
// Assumes: register file modelled here
// Notes: config changes only between frames with sclk idle, select may still be low
`timescale 1ns/100ps
module tb_serial_config_port;
    logic core_clk = 0, rst = 1, sclk, port_select_n, sdi, miso, sdio_in;
    logic sdio_out, sdio_oe, serial_data_out_pin, serial_data_out_oe, wr_strobe, busy;
    logic three_wire_cfg = 0, lsb_first_cfg = 0;
    logic [2:0] reg_bytes;
    logic [4:0] rd_addr, wr_addr, ga, a;
    logic [31:0] rd_data, wr_data, gd, wd, rdv, r, seed = 32'h124f8;
    logic [31:0] mem [32];
    int bad_count = 0, checks_done = 0, nstb = 0, cyc = 0, k, nb;
    scp_port DUT (.*);
    scp_host host (.*);
    assign sdio_in = sdio_oe ? sdio_out : sdi;
    // in four-wire mode a released output shows the inverse of the last host bit; in three-wire mode it shows that bit itself
    assign miso = three_wire_cfg ? sdio_in : serial_data_out_oe ? serial_data_out_pin : ~sdi;
    assign rd_data = mem[rd_addr];
    assign reg_bytes = width(rd_addr);
    function automatic logic [2:0] width(logic [4:0] x);
        return {1'b0, x[1:0]} + 3'h1;
    endfunction
    function automatic logic [31:0] msk(logic [2:0] n);
        return 32'hffffffff >> (32 - 8 * n);
    endfunction
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("errors %0d checks %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (wr_strobe) begin
            ga <= wr_addr;
            gd <= wr_data;
            nstb <= nstb + 1;
        end
        if (cyc == 50000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        for (int i = 0; i < 32; i++) mem[i] = rnd() & msk(width(5'(i)));
        repeat (8) @(posedge core_clk);
        rst <= 0;
        @(posedge core_clk);
        chk({sdio_oe, serial_data_out_oe, busy, wr_strobe}, 0);
        for (int n = 0; n < 30; n++) begin
            r = rnd();
            // odd passes run back to back with no resync between frames
            if (!n[0]) begin
                three_wire_cfg <= r[0];
                lsb_first_cfg <= r[1];
                @(posedge core_clk);
                host.resync();
            end
            a = r[8:4];
            nb = width(a);
            wd = rnd() & msk(3'(nb));
            k = nstb;
            host.keep_low = r[13];
            if (n == 6) begin
                host.xfer({1'b0, r[6:5], a}, wd, 0, lsb_first_cfg, -1, rdv);
                host.resync();
            end
            host.xfer({r[2], r[6:5], a}, wd, nb, lsb_first_cfg, r[3] ? int'(r[12:9]) : -1, rdv);
            repeat (10) @(posedge core_clk);
            chk(nstb, r[2] ? k : k + 1);
            if (r[2]) chk(rdv, mem[a]);
            else begin
                chk(ga, a);
                chk(gd, wd);
                mem[a] = wd;
            end
            chk(busy, 0);
        end
        test_done();
    end
endmodule
